// ===== rtl/fscr_pkg.sv
// Purpose: constants and types for the flash status/config register bank
// Assumes: three 8-bit registers selected by a 2-bit index
// Notes: bit positions follow the register layout of the device
package fscr_pkg;
  localparam logic [1:0] FSCR_SEL_ONE = 2'h0;
  localparam logic [1:0] FSCR_SEL_TWO = 2'h1;
  localparam logic [1:0] FSCR_SEL_THREE = 2'h2;
  // register one bit positions
  localparam int FSCR_B_BUSY = 0;
  localparam int FSCR_B_WEL = 1;
  localparam int FSCR_B_RANGE_LO = 2;
  localparam int FSCR_B_TOPBOT = 5;
  localparam int FSCR_B_UNIT = 6;
  localparam int FSCR_B_PMODE_LO = 7;
  // register two bit positions
  localparam int FSCR_B_PMODE_HI = 0;
  localparam int FSCR_B_QUAD = 1;
  localparam int FSCR_B_PSUS = 2;
  localparam int FSCR_B_LOCK_LO = 3;
  localparam int FSCR_B_CMP = 6;
  localparam int FSCR_B_ESUS = 7;
  // register three bit positions
  localparam int FSCR_B_DUMMY = 0;
  localparam int FSCR_B_SCHEME = 2;
  localparam int FSCR_B_HFM = 4;
  localparam int FSCR_B_DRV_LO = 5;
  localparam int FSCR_B_PINFN = 7;
  // writable masks (non-volatile/shadow fields)
  localparam logic [7:0] FSCR_WMASK_ONE = 8'hfc;
  localparam logic [7:0] FSCR_WMASK_TWO = 8'h7b;
  localparam logic [7:0] FSCR_SHMASK_TWO = 8'h43;
  localparam logic [7:0] FSCR_WMASK_THREE = 8'hf5;
  // factory reset values
  localparam logic [7:0] FSCR_RST_ONE = 8'h00;
  localparam logic [7:0] FSCR_RST_TWO = 8'h00;
  localparam logic [7:0] FSCR_RST_THREE = 8'h70;
  typedef enum logic [2:0] {
    FSCR_WE_NONE = 3'b001,
    FSCR_WE_NV = 3'b010,
    FSCR_WE_VOL = 3'b100
  } fscr_wen_t;
  typedef struct packed {
    logic [7:0] nv_one;
    logic [7:0] nv_two;
    logic [7:0] nv_three;
    logic [7:0] vo_one;
    logic [7:0] vo_two;
    logic [7:0] vo_three;
    fscr_wen_t wen;
    logic busy;
    logic esus;
    logic psus;
    logic [7:0] rdata;
    logic rvalid;
    logic nv_start;
    logic accept;
    logic wp_act;
    logic hold_act;
    logic rst_act;
  } fscr_state_t;
endpackage

// ===== rtl/fscr_regs.sv
// Purpose: status and configuration registers of a serial nor flash
// Assumes: command decoder delivers one-cycle strobes on the serial clock
// Notes: non-volatile cells modelled as flops kept across soft reset
//   pin-role outputs are registered with the rest of the state
// How it works
// - nv copies kept for protect, lock, quad bits
// - busy, latch, suspends read-only, internal only
// - latch set by write enable, cleared on done
// - nv write needs mode ok, enable, pin
// - shadow copies drive protection and quad outputs, nv copy drives lock outputs
// - power-up and soft reset load shadows
// - volatile enable then write touches shadows only
// - unit size picks block or sector granularity
// - top-bottom select sets protection direction
// - range bits default zero, zero unprotected
// - operations start only with latch set
// - busy reads one during embedded operation
// - erase suspended flag, resets zero
// - program suspended flag, resets zero
// - complement bit selects inverted map
// - lock bits one-time set, mark protected
// - quad off keeps protect pin, and hold or reset pin per pin function bit
// - drive strength bits, default both one
// - frequency mode bit defaults one
// - scheme bit selects range or block locks
// - dummy select bit, reserved bits zero
// - protect mode encoding gates all writes
// - busy ignores enables, writes and op requests
// - register write data never alters status flags
module fscr_regs
  import fscr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_soft_rst,
  input wire logic i_wren,
  input wire logic i_wren_vol,
  input wire logic i_wrdis,
  input wire logic i_op_req,
  input wire logic i_op_done,
  input wire logic i_sus_erase,
  input wire logic i_sus_prog,
  input wire logic i_resume,
  input wire logic i_wr_req,
  input wire logic [1:0] i_wr_sel,
  input wire logic [7:0] i_wr_data,
  input wire logic i_nv_done,
  input wire logic i_rd_req,
  input wire logic [1:0] i_rd_sel,
  input wire logic i_wp_pin,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_busy,
  output logic o_op_start,
  output logic o_nv_start,
  output logic o_unit_sector,
  output logic o_from_bottom,
  output logic [2:0] o_range,
  output logic o_complement,
  output logic [2:0] o_sec_lock,
  output logic o_quad,
  output logic o_wp_active,
  output logic o_hold_active,
  output logic o_reset_active,
  output logic [1:0] o_drive,
  output logic o_high_freq,
  output logic o_block_locks,
  output logic o_dummy_sel
);
  import fscr_pkg::*;
  fscr_state_t s_q, s_d;

  logic [1:0] pmode;
  logic locked;
  logic write_ok;
  logic op_ok;
  logic [7:0] rd_word;
  logic [7:0] wmask;
  logic [7:0] wval;
  logic [7:0] cur_nv;
  logic [7:0] cur_vo;

  always_comb
  begin
    pmode = {s_q.vo_two[FSCR_B_PMODE_HI], s_q.vo_one[FSCR_B_PMODE_LO]};
    // protect mode 00 free, 01 pin low locks when quad off, 1x locked
    locked = pmode[1] || (pmode[0] && !i_wp_pin && !s_q.vo_two[FSCR_B_QUAD]);
    // write needs a preceding enable and unlocked mode
    write_ok = (s_q.wen != FSCR_WE_NONE) && !locked;
    // embedded operation may start only with the latch set
    op_ok = i_op_req && (s_q.wen != FSCR_WE_NONE);

    // status flags merged over shadow values on read
    unique case (i_rd_sel)
      FSCR_SEL_ONE:
      begin
        rd_word = s_q.vo_one;
        rd_word[FSCR_B_WEL] = (s_q.wen != FSCR_WE_NONE);
        rd_word[FSCR_B_BUSY] = s_q.busy;
      end
      FSCR_SEL_TWO:
      begin
        rd_word = s_q.vo_two;
        rd_word[FSCR_B_ESUS] = s_q.esus;
        rd_word[FSCR_B_PSUS] = s_q.psus;
      end
      FSCR_SEL_THREE:
        rd_word = s_q.vo_three;
      default:
        rd_word = 8'h00;
    endcase

    unique case (i_wr_sel)
      FSCR_SEL_ONE:
      begin
        wmask = FSCR_WMASK_ONE;
        cur_nv = s_q.nv_one;
        cur_vo = s_q.vo_one;
      end
      FSCR_SEL_TWO:
      begin
        wmask = FSCR_WMASK_TWO;
        cur_nv = s_q.nv_two;
        cur_vo = s_q.vo_two;
      end
      default:
      begin
        wmask = FSCR_WMASK_THREE;
        cur_nv = s_q.nv_three;
        cur_vo = s_q.vo_three;
      end
    endcase

    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.nv_start = 1'b0;
    s_d.accept = 1'b0;
    wval = 8'h00;
    if (i_rd_req && i_rd_sel != 2'h3)
    begin
      s_d.rdata = rd_word;
      s_d.rvalid = 1'b1;
    end

    if (s_q.busy)
    begin
      // embedded operation finishes, latch dropped
      if (i_op_done || i_nv_done)
      begin
        s_d.busy = 1'b0;
        s_d.wen = FSCR_WE_NONE;
        if (i_nv_done)
        begin
          s_d.vo_one = (s_q.vo_one & ~FSCR_WMASK_ONE)
            | (s_q.nv_one & FSCR_WMASK_ONE);
          s_d.vo_two = (s_q.vo_two & ~FSCR_SHMASK_TWO)
            | (s_q.nv_two & FSCR_SHMASK_TWO);
          s_d.vo_three = s_q.nv_three;
        end
      end
      // other commands ignored while busy
    end
    else if (i_wren)
    begin
      s_d.wen = FSCR_WE_NV;
    end
    else if (i_wren_vol)
    begin
      s_d.wen = FSCR_WE_VOL;
    end
    else if (i_wrdis)
    begin
      s_d.wen = FSCR_WE_NONE;
    end
    else if (i_wr_req && i_wr_sel != 2'h3)
    begin
      // a refused write leaves the latch as it was
      if (write_ok)
      begin
        s_d.wen = FSCR_WE_NONE;
        if (s_q.wen == FSCR_WE_VOL)
        begin
          // shadow only, locks untouched, no nv cycle
          if (i_wr_sel == FSCR_SEL_TWO)
            wval = (cur_vo & ~FSCR_SHMASK_TWO)
              | (i_wr_data & FSCR_SHMASK_TWO);
          else
            wval = (cur_vo & ~wmask) | (i_wr_data & wmask);
          unique case (i_wr_sel)
            FSCR_SEL_ONE: s_d.vo_one = wval;
            FSCR_SEL_TWO: s_d.vo_two = wval;
            default: s_d.vo_three = wval;
          endcase
        end
        else
        begin
          // lock bits only ever set
          wval = (cur_nv & ~wmask) | (i_wr_data & wmask);
          if (i_wr_sel == FSCR_SEL_TWO)
            wval[FSCR_B_LOCK_LO +: 3] = cur_nv[FSCR_B_LOCK_LO +: 3]
              | i_wr_data[FSCR_B_LOCK_LO +: 3];
          unique case (i_wr_sel)
            FSCR_SEL_ONE: s_d.nv_one = wval;
            FSCR_SEL_TWO: s_d.nv_two = wval;
            default: s_d.nv_three = wval;
          endcase
          if (i_wr_sel == FSCR_SEL_TWO)
            s_d.vo_two[FSCR_B_LOCK_LO +: 3] = wval[FSCR_B_LOCK_LO +: 3];
          s_d.busy = 1'b1;
          s_d.nv_start = 1'b1;
        end
      end
    end
    else if (op_ok)
    begin
      s_d.busy = 1'b1;
      s_d.accept = 1'b1;
    end

    // suspend flags, set wins over resume
    if (i_resume)
    begin
      s_d.esus = 1'b0;
      s_d.psus = 1'b0;
    end
    if (i_sus_erase)
      s_d.esus = 1'b1;
    if (i_sus_prog)
      s_d.psus = 1'b1;

    if (i_soft_rst)
    begin
      // reload shadows, volatile status cleared
      s_d.vo_one = s_q.nv_one;
      s_d.vo_two = s_q.nv_two;
      s_d.vo_three = s_q.nv_three;
      // power-supply lock mode released by reset
      if (s_q.nv_two[FSCR_B_PMODE_HI] && !s_q.nv_one[FSCR_B_PMODE_LO])
        s_d.vo_two[FSCR_B_PMODE_HI] = 1'b0;
      s_d.wen = FSCR_WE_NONE;
      s_d.busy = 1'b0;
      s_d.esus = 1'b0;
      s_d.psus = 1'b0;
      s_d.nv_start = 1'b0;
      s_d.accept = 1'b0;
    end

    // pin roles follow the shadow quad and pin function bits
    s_d.wp_act = !s_d.vo_two[FSCR_B_QUAD];
    s_d.hold_act = !s_d.vo_two[FSCR_B_QUAD]
      && !s_d.vo_three[FSCR_B_PINFN];
    s_d.rst_act = !s_d.vo_two[FSCR_B_QUAD]
      && s_d.vo_three[FSCR_B_PINFN];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      // power-up: nv defaults, shadows loaded from them
      s_q.nv_one <= FSCR_RST_ONE;
      s_q.nv_two <= FSCR_RST_TWO;
      s_q.nv_three <= FSCR_RST_THREE;
      s_q.vo_one <= FSCR_RST_ONE;
      s_q.vo_two <= FSCR_RST_TWO;
      s_q.vo_three <= FSCR_RST_THREE;
      s_q.wen <= FSCR_WE_NONE;
      s_q.busy <= 1'b0;
      s_q.esus <= 1'b0;
      s_q.psus <= 1'b0;
      s_q.rdata <= 8'h00;
      s_q.rvalid <= 1'b0;
      s_q.nv_start <= 1'b0;
      s_q.accept <= 1'b0;
      s_q.wp_act <= !FSCR_RST_TWO[FSCR_B_QUAD];
      s_q.hold_act <= !FSCR_RST_TWO[FSCR_B_QUAD]
        && !FSCR_RST_THREE[FSCR_B_PINFN];
      s_q.rst_act <= !FSCR_RST_TWO[FSCR_B_QUAD]
        && FSCR_RST_THREE[FSCR_B_PINFN];
    end
    else
      s_q <= s_d;
  end

  // outputs taken from shadow flops, lock bits from the nv copy
  assign o_rd_data = s_q.rdata;
  assign o_rd_valid = s_q.rvalid;
  assign o_busy = s_q.busy;
  assign o_op_start = s_q.accept;
  assign o_nv_start = s_q.nv_start;
  assign o_unit_sector = s_q.vo_one[FSCR_B_UNIT];
  assign o_from_bottom = s_q.vo_one[FSCR_B_TOPBOT];
  assign o_range = s_q.vo_one[FSCR_B_RANGE_LO +: 3];
  assign o_complement = s_q.vo_two[FSCR_B_CMP];
  assign o_sec_lock = s_q.nv_two[FSCR_B_LOCK_LO +: 3];
  assign o_quad = s_q.vo_two[FSCR_B_QUAD];
  assign o_wp_active = s_q.wp_act;
  assign o_hold_active = s_q.hold_act;
  assign o_reset_active = s_q.rst_act;
  assign o_drive = s_q.vo_three[FSCR_B_DRV_LO +: 2];
  assign o_high_freq = s_q.vo_three[FSCR_B_HFM];
  assign o_block_locks = s_q.vo_three[FSCR_B_SCHEME];
  assign o_dummy_sel = s_q.vo_three[FSCR_B_DUMMY];
endmodule

// ===== sim/fscr_regs_asserts.sv
// Purpose: port assertions for the register bank
// Assumes: one clock, sync active-low reset
// Notes: bound onto fscr_regs
module fscr_regs_chk
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_soft_rst,
  input wire logic i_op_req,
  input wire logic i_op_done,
  input wire logic i_nv_done,
  input wire logic i_rd_req,
  input wire logic [1:0] i_rd_sel,
  input wire logic o_rd_valid,
  input wire logic o_busy,
  input wire logic o_op_start,
  input wire logic o_nv_start,
  input wire logic o_quad,
  input wire logic o_hold_active,
  input wire logic o_reset_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rd_lat; i_rd_req && i_rd_sel != 2'h3 |=> o_rd_valid;
  endproperty
  property p_rd_why; o_rd_valid |-> $past(i_rd_req); endproperty
  property p_nv_busy; o_nv_start |-> o_busy; endproperty
  property p_op_go; o_op_start |-> $past(i_op_req) && !$past(o_busy);
  endproperty
  property p_busy_up; $rose(o_busy) |-> o_nv_start || o_op_start;
  endproperty
  property p_busy_keep;
    o_busy && !i_op_done && !i_nv_done && !i_soft_rst |=> o_busy;
  endproperty
  property p_busy_end; o_busy && (i_op_done || i_nv_done) |=> !o_busy;
  endproperty
  property p_pin_off; o_quad |-> !o_hold_active && !o_reset_active;
  endproperty
  property p_pin_one; !o_quad |-> o_hold_active != o_reset_active;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("no read answer");
  a_rd_why: assert property (p_rd_why) else $error("stray answer");
  a_nv_busy: assert property (p_nv_busy) else $error("idle write");
  a_op_go: assert property (p_op_go) else $error("bad start");
  a_busy_up: assert property (p_busy_up) else $error("busy cause");
  a_busy_keep: assert property (p_busy_keep) else $error("busy drop");
  a_busy_end: assert property (p_busy_end) else $error("busy stuck");
  a_pin_off: assert property (p_pin_off) else $error("pins on");
  a_pin_one: assert property (p_pin_one) else $error("pin fn");
  c_rd: cover property (o_rd_valid);
  c_nv: cover property (o_nv_start);
  c_op: cover property (o_op_start);
endmodule
bind fscr_regs fscr_regs_chk chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_soft_rst(i_soft_rst), .i_op_req(i_op_req), .i_op_done(i_op_done),
  .i_nv_done(i_nv_done), .i_rd_req(i_rd_req), .i_rd_sel(i_rd_sel),
  .o_rd_valid(o_rd_valid),
  .o_busy(o_busy), .o_op_start(o_op_start), .o_nv_start(o_nv_start),
  .o_quad(o_quad), .o_hold_active(o_hold_active),
  .o_reset_active(o_reset_active));

// ===== sim/fscr_host.sv
// Purpose: host controller model issuing register commands
// Assumes: strobes change at the falling edge
// Notes: released select and data lines show the inverse value
module fscr_host
(
  input wire logic i_clk,
  output logic [9:0] o_ev,
  output logic o_wr_req,
  output logic o_rd_req,
  output logic [1:0] o_sel,
  output logic [7:0] o_wdata,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_ev = '0;
    o_wr_req = 1'b0;
    o_rd_req = 1'b0;
    o_sel = 2'h0;
    o_wdata = 8'h00;
  end
  // one-cycle event pulse
  task automatic ev(input int b);
    @(negedge i_clk);
    o_ev[b] = 1'b1;
    @(negedge i_clk);
    o_ev[b] = 1'b0;
  endtask
  // register write, preceded by an enable pulse from the caller
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge i_clk);
    o_sel = s;
    o_wdata = d;
    o_wr_req = 1'b1;
    @(negedge i_clk);
    o_wr_req = 1'b0;
    o_sel = ~s;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(negedge i_clk);
    o_sel = s;
    o_rd_req = 1'b1;
    @(negedge i_clk);
    o_rd_req = 1'b0;
    o_sel = ~s;
    d = i_rd_valid ? i_rd_data : 8'hxx;
  endtask
endmodule

// ===== sim/fscr_regs_tb.sv
// Purpose: self-checking bench for the register bank
// Assumes: host model drives commands at the falling edge
// Notes: event bits 9..0 soft reset, enable, volatile enable,
//   disable, op request, op done, suspends, resume, write done
module fscr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wp_pin = 1'b1;
  wire logic i_soft_rst, i_wren, i_wren_vol, i_wrdis, i_op_req, i_op_done;
  wire logic i_sus_erase, i_sus_prog, i_resume, i_nv_done, i_wr_req;
  wire logic i_rd_req;
  wire logic [1:0] i_wr_sel, i_rd_sel;
  wire logic [7:0] i_wr_data;
  logic [7:0] o_rd_data;
  logic o_rd_valid, o_busy, o_op_start, o_nv_start, o_unit_sector;
  logic o_from_bottom, o_complement, o_quad, o_wp_active, o_hold_active;
  logic o_reset_active, o_high_freq, o_block_locks, o_dummy_sel;
  logic [2:0] o_range, o_sec_lock;
  logic [1:0] o_drive;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  wire logic [9:0] ev;
  assign i_rd_sel = i_wr_sel;
  assign {i_soft_rst, i_wren, i_wren_vol, i_wrdis, i_op_req, i_op_done,
    i_sus_erase, i_sus_prog, i_resume, i_nv_done} = ev;
  fscr_regs dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_soft_rst(i_soft_rst), .i_wren(i_wren), .i_wren_vol(i_wren_vol),
    .i_wrdis(i_wrdis), .i_op_req(i_op_req), .i_op_done(i_op_done),
    .i_sus_erase(i_sus_erase), .i_sus_prog(i_sus_prog),
    .i_resume(i_resume), .i_wr_req(i_wr_req), .i_wr_sel(i_wr_sel),
    .i_wr_data(i_wr_data), .i_nv_done(i_nv_done), .i_rd_req(i_rd_req),
    .i_rd_sel(i_rd_sel), .i_wp_pin(i_wp_pin), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_busy(o_busy), .o_op_start(o_op_start),
    .o_nv_start(o_nv_start), .o_unit_sector(o_unit_sector),
    .o_from_bottom(o_from_bottom), .o_range(o_range),
    .o_complement(o_complement), .o_sec_lock(o_sec_lock), .o_quad(o_quad),
    .o_wp_active(o_wp_active), .o_hold_active(o_hold_active),
    .o_reset_active(o_reset_active), .o_drive(o_drive),
    .o_high_freq(o_high_freq), .o_block_locks(o_block_locks),
    .o_dummy_sel(o_dummy_sel));
  fscr_host host_u (.i_clk(i_clk), .o_ev(ev), .o_wr_req(i_wr_req),
    .o_rd_req(i_rd_req),
    .o_sel(i_wr_sel), .o_wdata(i_wr_data), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data));
  always #10 i_clk = ~i_clk;
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [1:0] s, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(s, d);
    chk(d, exp);
  endtask
  initial
  begin
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk_rd(0, 8'h00);
    chk_rd(1, 8'h00);
    chk_rd(2, 8'h70);
    chk({1'b0, o_drive, o_high_freq, o_wp_active, o_hold_active,
      o_reset_active, o_quad}, 8'h7c);
    host_u.wr(0, 8'hfc);
    chk({6'h0, o_nv_start, o_busy}, 8'h00);
    chk_rd(0, 8'h00);
    host_u.ev(8);
    host_u.ev(6);
    chk_rd(0, 8'h00);
    host_u.ev(8);
    chk_rd(0, 8'h02);
    host_u.wr(0, 8'hff);
    chk({6'h0, o_nv_start, o_busy}, 8'h03);
    chk_rd(0, 8'h01);
    host_u.ev(8);
    host_u.ev(0);
    chk_rd(0, 8'hfc);
    chk({3'h0, o_unit_sector, o_from_bottom, o_range}, 8'h1f);
    i_wp_pin = 1'b0;
    host_u.ev(8);
    host_u.wr(0, 8'h00);
    chk_rd(0, 8'hfe);
    i_wp_pin = 1'b1;
    host_u.wr(0, 8'h00);
    host_u.ev(0);
    chk_rd(0, 8'h00);
    host_u.ev(7);
    host_u.wr(1, 8'h43);
    chk({1'b0, o_nv_start, o_busy, o_quad, o_complement, o_wp_active,
      o_hold_active,
      o_reset_active}, 8'h18);
    host_u.ev(7);
    host_u.wr(1, 8'h00);
    chk_rd(1, 8'h43);
    host_u.ev(9);
    chk_rd(1, 8'h00);
    host_u.ev(8);
    host_u.wr(2, 8'h8f);
    repeat (5) @(negedge i_clk);
    host_u.ev(0);
    chk_rd(2, 8'h85);
    chk({1'b0, o_reset_active, o_hold_active, o_drive, o_high_freq,
      o_block_locks, o_dummy_sel}, 8'h43);
    host_u.ev(8);
    host_u.wr(1, 8'h38);
    host_u.ev(0);
    chk({5'h0, o_sec_lock}, 8'h07);
    host_u.ev(8);
    host_u.wr(1, 8'h00);
    host_u.ev(0);
    chk_rd(1, 8'h38);
    host_u.ev(5);
    chk({6'h0, o_op_start, o_busy}, 8'h00);
    host_u.ev(8);
    host_u.ev(5);
    chk({6'h0, o_op_start, o_busy}, 8'h03);
    host_u.ev(3);
    host_u.ev(2);
    chk_rd(1, 8'hbc);
    host_u.ev(1);
    chk_rd(1, 8'h38);
    host_u.ev(4);
    chk_rd(0, 8'h00);
    tally_and_finish();
  end
endmodule
